// ### sfwp_defines.vh
// Constants for the serial flash write protection and power mode block
`ifndef SFWP_DEFINES_VH
`define SFWP_DEFINES_VH

// ****************************************************************
// Command codes (arbitrary values, set to match the host decoder)
// ****************************************************************
`define SFWP_OP_WRITE_ENABLE_CMD     8'h10
`define SFWP_OP_WRITE_DISABLE_CMD     8'h11
`define SFWP_OP_SRW      8'h12
`define SFWP_OP_SRW4     8'h13
`define SFWP_OP_PROG     8'h14
`define SFWP_OP_QPROG    8'h15
`define SFWP_OP_SECT     8'h16
`define SFWP_OP_HBLK     8'h17
`define SFWP_OP_BLK      8'h18
`define SFWP_OP_CHIP     8'h19
`define SFWP_OP_DPD      8'h1a
`define SFWP_OP_REL      8'h1b

// ****************************************************************
// Clock pulse counts at which command bytes are complete
// ****************************************************************
`define SFWP_CNT_OP      6'd7
`define SFWP_CNT_B1      6'd15
`define SFWP_CNT_B2      6'd23
`define SFWP_CNT_B3      6'd31
`define SFWP_CNT_MAX     6'd63
`define SFWP_LEN_OP      6'd8
`define SFWP_LEN_SRW     6'd16
`define SFWP_LEN_ERASE   6'd32
`define SFWP_LEN_PROG    6'd40
`define SFWP_MOD_LAST    3'd7

// ****************************************************************
// Pin idle levels after reset: clock low, select high, protect high
// ****************************************************************
`define SFWP_SYNC_IDLE   4'h6

// ****************************************************************
// Memory geometry, 512KB array
// ****************************************************************
`define SFWP_MEM_TOP     20'h7ffff
`define SFWP_MEM_SIZE    20'h80000
`define SFWP_MASK_PAGE   20'h000ff
`define SFWP_MASK_SECT   20'h00fff
`define SFWP_MASK_HBLK   20'h07fff
`define SFWP_MASK_BLK    20'h0ffff
`define SFWP_SZ_4K       20'h01000
`define SFWP_SZ_8K       20'h02000
`define SFWP_SZ_16K      20'h04000
`define SFWP_SZ_32K      20'h08000
`define SFWP_SZ_64K      20'h10000
`define SFWP_SZ_128K     20'h20000
`define SFWP_SZ_256K     20'h40000
`define SFWP_BP_NONE     3'b000
`define SFWP_BP_ALL_SECT 3'b111

// ****************************************************************
// Status data byte fields
// ****************************************************************
`define SFWP_SR_LOCK     7
`define SFWP_SR_GRAN     6
`define SFWP_SR_TB       5
`define SFWP_SR_BP_HI    4
`define SFWP_SR_BP_LO    2
`define SFWP_SR4_CMP     0
`define SFWP_SR4_PDIS    1
`define SFWP_SR4_HDIS    2

// ****************************************************************
// Timing defaults in core clock cycles
// ****************************************************************
`define SFWP_PUW_CYC     16'd2000
`define SFWP_SRW_CYC     16'd200
`define SFWP_PROG_CYC    16'd400
`define SFWP_ERASE_CYC   16'd4000
`define SFWP_ONE         16'd1

`endif

// ### sfwp_sync.v
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ns
module sfwp_sync #(
   parameter         W       = 1,
   parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
   input  wire         i_core_clk,
   input  wire         i_srst,
   input  wire [W-1:0] i_async,
   output reg  [W-1:0] o_sync
);
   reg [W-1:0] meta_r;

   // First stage feeds only the second stage
   always @(posedge i_core_clk) begin
      if (i_srst) begin
         meta_r <= RST_VAL;
         o_sync <= RST_VAL;
      end else begin
         meta_r <= i_async;
         o_sync <= meta_r;
      end
   end
endmodule

// ### sfwp_core.v
// Write protection, busy tracking and power modes of a serial flash
//
// Summary of operation
// - Busy bit reports running internal cycle
// - Chip select low means selected, active unless in deep power-down
// - Deselected stays active until cycle ends
// - Deep power-down command enters low power
// - Only release command leaves deep power-down
// - Modifying commands need pulses multiple of eight
// - Modifying commands need write enable latch set
// - Latch clears at reset and completions
// - Power-up timer blocks modifying commands
// - Protect bits make region read-only
// - Protect pin locks configuration bits
// - Top blocks protected by code
// - Bottom blocks protected by code
// - Top sectors protected by code
// - Bottom sectors protected by code
// - Program or erase touching protection ignored
// - Complement bit inverts protected region
`timescale 1ns/1ns
`include "sfwp_defines.vh"
module sfwp_core #(
   parameter [15:0] PUW_CYC   = `SFWP_PUW_CYC,
   parameter [15:0] SRW_CYC   = `SFWP_SRW_CYC,
   parameter [15:0] PROG_CYC  = `SFWP_PROG_CYC,
   parameter [15:0] ERASE_CYC = `SFWP_ERASE_CYC
) (
   input  wire       i_core_clk,
   input  wire       i_srst,
   input  wire       i_spi_clk,
   input  wire       i_spi_cs_n,
   input  wire       i_spi_di,
   input  wire       i_wp_n,
   output reg        o_write_in_progress,
   output reg        o_write_enable_latch,
   output reg        o_deep_power_down,
   output reg        o_active_mode,
   output reg        o_standby_mode,
   output reg        o_write_blocked,
   output reg        o_cmd_rejected,
   output reg  [2:0] o_block_protect,
   output reg        o_top_bottom_select,
   output reg        o_sector_granularity_select,
   output reg        o_protect_complement,
   output reg        o_protect_pin_disable,
   output reg        o_hold_disable_bit,
   output reg        o_status_lock_bit
);
   // ****************************************************************
   // Pin sampling
   // ****************************************************************
   wire [3:0] sync_w;
   wire       sclk_s;
   wire       cs_n_s;
   wire       di_s;
   wire       wp_n_s;
   reg        sclk_d_r;
   reg        cs_d_r;

   sfwp_sync #(.W(4), .RST_VAL(`SFWP_SYNC_IDLE)) u_sync (
      .i_core_clk (i_core_clk),
      .i_srst     (i_srst),
      .i_async    ({i_spi_clk, i_spi_cs_n, i_wp_n, i_spi_di}),
      .o_sync     (sync_w)
   );
   assign sclk_s = sync_w[3];
   assign cs_n_s = sync_w[2];
   assign wp_n_s = sync_w[1];
   assign di_s   = sync_w[0];

   wire sclk_rise = sclk_s & ~sclk_d_r;
   wire cs_fall   = ~cs_n_s & cs_d_r;
   wire cs_rise   = cs_n_s & ~cs_d_r;

   // ****************************************************************
   // Command capture
   // ****************************************************************
   reg [5:0]  cnt_r;
   reg [2:0]  mod_r;
   reg [6:0]  sh_r;
   reg [7:0]  op_r;
   reg [7:0]  b1_r;
   reg [7:0]  b2_r;
   reg [7:0]  b3_r;
   wire [7:0] byte_w = {sh_r, di_s};

   always @(posedge i_core_clk) begin
      sclk_d_r <= sclk_s;
      cs_d_r   <= cs_n_s;
      if (i_srst) begin
         cnt_r <= 6'd0;
         mod_r <= 3'd0;
         sh_r  <= 7'd0;
         op_r  <= 8'h00;
         b1_r  <= 8'h00;
         b2_r  <= 8'h00;
         b3_r  <= 8'h00;
      end else if (cs_fall) begin
         cnt_r <= 6'd0;
         mod_r <= 3'd0;
         op_r  <= 8'h00;
      end else if (~cs_n_s && sclk_rise) begin
         sh_r  <= byte_w[6:0];
         mod_r <= mod_r + 3'd1;
         if (cnt_r != `SFWP_CNT_MAX) begin
            cnt_r <= cnt_r + 6'd1;
         end
         if (cnt_r == `SFWP_CNT_OP) begin
            op_r <= byte_w;
         end else if (cnt_r == `SFWP_CNT_B1) begin
            b1_r <= byte_w;
         end else if (cnt_r == `SFWP_CNT_B2) begin
            b2_r <= byte_w;
         end else if (cnt_r == `SFWP_CNT_B3) begin
            b3_r <= byte_w;
         end
      end
   end

   // ****************************************************************
   // Protected region
   // ****************************************************************
   reg [19:0] sz;
   reg        base_all;
   reg        base_none;
   reg [19:0] plo;
   reg [19:0] phi;
   reg        p_all;
   reg        p_none;

   always @* begin
      sz        = `SFWP_SZ_4K;
      base_all  = 1'b0;
      base_none = (o_block_protect == `SFWP_BP_NONE);
      if (o_sector_granularity_select) begin
         case (o_block_protect)
            3'b001:  sz = `SFWP_SZ_4K;
            3'b010:  sz = `SFWP_SZ_8K;
            3'b011:  sz = `SFWP_SZ_16K;
            3'b111:  base_all = 1'b1;
            default: sz = `SFWP_SZ_32K;
         endcase
      end else begin
         case (o_block_protect)
            3'b001:  sz = `SFWP_SZ_64K;
            3'b010:  sz = `SFWP_SZ_128K;
            3'b011:  sz = `SFWP_SZ_256K;
            default: base_all = ~base_none;
         endcase
      end
      if (o_top_bottom_select) begin
         plo = 20'h00000;
         phi = sz - `SFWP_SZ_4K + `SFWP_MASK_SECT;
      end else begin
         plo = `SFWP_MEM_SIZE - sz;
         phi = `SFWP_MEM_TOP;
      end
      p_all  = base_all;
      p_none = base_none;
      if (o_protect_complement) begin
         p_all  = base_none;
         p_none = base_all;
         if (o_top_bottom_select) begin
            plo = phi + `SFWP_SZ_4K - `SFWP_MASK_SECT;
            phi = `SFWP_MEM_TOP;
         end else begin
            phi = plo - 20'h00001;
            plo = 20'h00000;
         end
      end
   end

   // ****************************************************************
   // Command judgement at deselection
   // ****************************************************************
   reg [19:0] mask;
   reg        is_mem;
   reg        len_ok;
   reg [15:0] dur;
   wire [19:0] addr = {1'b0, b1_r[2:0], b2_r, b3_r};
   wire [19:0] rlo  = addr & ~mask;
   wire [19:0] rhi  = (addr | mask) & `SFWP_MEM_TOP;
   wire        hit  = ~p_none & (p_all | ((rlo <= phi) & (rhi >= plo)));
   wire        is_srw = (op_r == `SFWP_OP_SRW) | (op_r == `SFWP_OP_SRW4);
   wire        hardware_protected_mode    = o_status_lock_bit & ~wp_n_s & ~o_protect_pin_disable;

   always @* begin
      mask   = `SFWP_MASK_PAGE;
      is_mem = 1'b1;
      len_ok = (cnt_r >= `SFWP_LEN_ERASE);
      dur    = ERASE_CYC;
      case (op_r)
         `SFWP_OP_PROG, `SFWP_OP_QPROG: begin
            len_ok = (cnt_r >= `SFWP_LEN_PROG);
            dur    = PROG_CYC;
         end
         `SFWP_OP_SECT:  mask = `SFWP_MASK_SECT;
         `SFWP_OP_HBLK:  mask = `SFWP_MASK_HBLK;
         `SFWP_OP_BLK:   mask = `SFWP_MASK_BLK;
         `SFWP_OP_CHIP: begin
            mask   = `SFWP_MEM_TOP;
            len_ok = (cnt_r >= `SFWP_LEN_OP);
         end
         default: begin
            is_mem = 1'b0;
            len_ok = (cnt_r >= `SFWP_LEN_SRW);
            dur    = SRW_CYC;
         end
      endcase
   end

   wire is_mod  = is_mem | is_srw;
   wire mod_ok  = (mod_r == 3'd0) & len_ok;
   wire gate_ok = o_write_enable_latch & ~o_write_blocked & mod_ok;
   wire accept  = is_mod & gate_ok & (is_mem ? ~hit : ~hardware_protected_mode);

   // ****************************************************************
   // State: latch, busy, power modes, status bits
   // ****************************************************************
   reg [15:0] busy_cnt_r;
   reg [15:0] puw_cnt_r;
   wire       selected = ~cs_n_s;

   always @(posedge i_core_clk) begin
      if (i_srst) begin
         o_write_in_progress         <= 1'b0;
         o_write_enable_latch        <= 1'b0;
         o_deep_power_down           <= 1'b0;
         o_active_mode               <= 1'b0;
         o_standby_mode              <= 1'b1;
         o_write_blocked             <= 1'b1;
         o_cmd_rejected              <= 1'b0;
         o_block_protect             <= 3'b000;
         o_top_bottom_select         <= 1'b0;
         o_sector_granularity_select <= 1'b0;
         o_protect_complement        <= 1'b0;
         o_protect_pin_disable       <= 1'b0;
         o_hold_disable_bit          <= 1'b0;
         o_status_lock_bit           <= 1'b0;
         busy_cnt_r                  <= 16'd0;
         puw_cnt_r                   <= 16'd0;
      end else begin
         o_cmd_rejected <= 1'b0;
         // Writes stay blocked until the supply has had time to settle
         if (puw_cnt_r != PUW_CYC) begin
            puw_cnt_r <= puw_cnt_r + `SFWP_ONE;
         end
         o_write_blocked <= (puw_cnt_r != PUW_CYC);
         // Modes follow current-cycle status, one cycle late, so outputs stay registered
         o_active_mode  <= ~o_deep_power_down & (selected | o_write_in_progress);
         o_standby_mode <= ~o_deep_power_down & ~selected & ~o_write_in_progress;
         if (o_write_in_progress) begin
            busy_cnt_r <= busy_cnt_r - `SFWP_ONE;
            if (busy_cnt_r == `SFWP_ONE) begin
               o_write_in_progress  <= 1'b0;
               o_write_enable_latch <= 1'b0;
            end
            // Host traffic during a cycle is dropped; any command ended then is flagged as rejected
            if (cs_rise && (cnt_r != 6'd0)) begin
               o_cmd_rejected <= 1'b1;
            end
         end else if (cs_rise && (cnt_r != 6'd0)) begin
            if (o_deep_power_down) begin
               if (op_r == `SFWP_OP_REL) begin
                  o_deep_power_down <= 1'b0;
               end else begin
                  o_cmd_rejected <= 1'b1;
               end
            end else if (op_r == `SFWP_OP_WRITE_ENABLE_CMD) begin
               o_write_enable_latch <= 1'b1;
            end else if (op_r == `SFWP_OP_WRITE_DISABLE_CMD) begin
               o_write_enable_latch <= 1'b0;
            end else if (op_r == `SFWP_OP_DPD) begin
               o_deep_power_down <= 1'b1;
               o_active_mode     <= 1'b0;
               o_standby_mode    <= 1'b0;
            end else if (accept) begin
               o_write_in_progress <= 1'b1;
               busy_cnt_r          <= dur;
               if (op_r == `SFWP_OP_SRW) begin
                  o_status_lock_bit           <= b1_r[`SFWP_SR_LOCK];
                  o_sector_granularity_select <= b1_r[`SFWP_SR_GRAN];
                  o_top_bottom_select         <= b1_r[`SFWP_SR_TB];
                  o_block_protect             <= b1_r[`SFWP_SR_BP_HI:`SFWP_SR_BP_LO];
               end else if (op_r == `SFWP_OP_SRW4) begin
                  o_protect_complement  <= b1_r[`SFWP_SR4_CMP];
                  o_protect_pin_disable <= b1_r[`SFWP_SR4_PDIS];
                  o_hold_disable_bit    <= b1_r[`SFWP_SR4_HDIS];
               end
            end else begin
               o_cmd_rejected <= 1'b1;
            end
         end
      end
   end
endmodule

// ### sfwp_props.sv
// Assertion checker for the write protect and power block
`timescale 1ns/1ns
module sfwp_props #(
   parameter [15:0] PUW_CYC   = 16'd2000,
   parameter [15:0] ERASE_CYC = 16'd4000
) (
   input wire       i_core_clk,
   input wire       i_srst,
   input wire       o_write_in_progress,
   input wire       o_write_enable_latch,
   input wire       o_deep_power_down,
   input wire       o_active_mode,
   input wire       o_standby_mode,
   input wire       o_write_blocked,
   input wire       o_cmd_rejected,
   input wire [2:0] o_block_protect
);
   int cyc_r;
   int busy_r;
   // Saturate so a long run never wraps the age count
   always @(posedge i_core_clk) begin
      if (i_srst) cyc_r <= 0;
      else if (cyc_r < 100000) cyc_r <= cyc_r + 1;
      if (i_srst || !o_write_in_progress) busy_r <= 0;
      else busy_r <= busy_r + 1;
   end
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (i_srst);
   sequence busy_hold_s;
      o_write_in_progress [*8];
   endsequence
   sequence busy_start_s;
      $rose(o_write_in_progress);
   endsequence
   latch_before_busy_a: assert property (busy_start_s |-> $past(o_write_enable_latch))
      else $error("busy rose with latch clear");
   blocked_no_busy_a: assert property (o_write_blocked |-> !o_write_in_progress)
      else $error("busy while power-up timer runs");
   puw_time_a: assert property ($fell(o_write_blocked) |-> cyc_r >= PUW_CYC && cyc_r <= PUW_CYC + 2)
      else $error("power-up timer length wrong");
   busy_min_a: assert property (busy_start_s |-> busy_hold_s)
      else $error("busy too short");
   busy_max_a: assert property (o_write_in_progress |-> busy_r <= ERASE_CYC)
      else $error("busy too long");
   drop_together_a: assert property ($fell(o_write_in_progress) |-> $fell(o_write_enable_latch))
      else $error("latch not cleared at completion");
   mode_excl_a: assert property (!(o_active_mode && o_standby_mode))
      else $error("active and standby together");
   busy_active_a: assert property (o_write_in_progress && $past(o_write_in_progress) |-> !o_standby_mode)
      else $error("standby while busy");
   dpd_entry_a: assert property ($rose(o_deep_power_down) |-> !$past(o_write_in_progress))
      else $error("power-down entered while busy");
   dpd_frozen_a: assert property (o_deep_power_down && $past(o_deep_power_down) |->
      $stable(o_write_enable_latch) && !$rose(o_write_in_progress))
      else $error("command acted on in power-down");
   cfg_change_a: assert property (!$stable(o_block_protect) |-> $rose(o_write_in_progress))
      else $error("protect bits changed outside status write");
   reject_pulse_a: assert property (o_cmd_rejected |=> !o_cmd_rejected)
      else $error("reject pulse too long");
endmodule
bind sfwp_core sfwp_props #(.PUW_CYC(PUW_CYC), .ERASE_CYC(ERASE_CYC)) u_props (.i_core_clk, .i_srst,
   .o_write_in_progress, .o_write_enable_latch, .o_deep_power_down, .o_active_mode, .o_standby_mode,
   .o_write_blocked, .o_cmd_rejected, .o_block_protect);

// ### sfwp_host.sv
// Host controller model driving the serial command pins
`timescale 1ns/1ns
module sfwp_host (
   output logic o_spi_clk,
   output logic o_spi_cs_n,
   output logic o_spi_di
);
   initial begin
      o_spi_clk = 1'b0;
      o_spi_cs_n = 1'b1;
      o_spi_di = 1'b0;
   end
   // Left-aligned frame of n pulses; clock rests low, data inverted once released
   task automatic send(input logic [39:0] d, input int n);
      #17 o_spi_cs_n = 1'b0;
      for (int i = 0; i < n; i++) begin
         o_spi_di = d[39 - (i % 40)];
         #200 o_spi_clk = 1'b1;
         #200 o_spi_clk = 1'b0;
      end
      #100 o_spi_cs_n = 1'b1;
      o_spi_di = ~o_spi_di;
      #250;
   endtask
endmodule

// ### sfwp_core_bench.sv
// Self-checking bench for the write protect and power block
`timescale 1ns/1ns
`include "sfwp_defines.vh"
module sfwp_core_bench;
   logic i_core_clk = 1'b0;
   logic i_srst = 1'b1;
   logic i_wp_n = 1'b1;
   logic spi_clk, cs_n, di, write_in_progress, write_enable_latch, dpd, act, stby, blk, rej, gran, tb, cmp, pdis, hdis, lock;
   logic [2:0] bp;
   int fail_count = 0, n_compared = 0, cyc = 0, rej_cnt = 0, run = 0, last_len = 0;
   sfwp_core #(.PUW_CYC(16'd300), .SRW_CYC(16'd10), .PROG_CYC(16'd12), .ERASE_CYC(16'd16)) dut (
      .i_core_clk(i_core_clk), .i_srst(i_srst), .i_spi_clk(spi_clk), .i_spi_cs_n(cs_n), .i_spi_di(di),
      .i_wp_n(i_wp_n), .o_write_in_progress(write_in_progress), .o_write_enable_latch(write_enable_latch), .o_deep_power_down(dpd),
      .o_active_mode(act), .o_standby_mode(stby), .o_write_blocked(blk), .o_cmd_rejected(rej),
      .o_block_protect(bp), .o_top_bottom_select(tb), .o_sector_granularity_select(gran),
      .o_protect_complement(cmp), .o_protect_pin_disable(pdis), .o_hold_disable_bit(hdis),
      .o_status_lock_bit(lock));
   sfwp_host host (.o_spi_clk(spi_clk), .o_spi_cs_n(cs_n), .o_spi_di(di));
   initial forever #25 i_core_clk = ~i_core_clk;
   always @(posedge i_core_clk) begin
      cyc <= cyc + 1;
      if (rej === 1'b1) rej_cnt <= rej_cnt + 1;
      if (write_in_progress === 1'b1) run <= run + 1;
      else if (run != 0) begin
         last_len <= run;
         run <= 0;
      end
      if (cyc == 60000) begin
         fail_count++;
         summarize();
      end
   end
   task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %0h seen %0h", nm, exp, got);
      end
   endtask
   task automatic settle();
      int k;
      k = 0;
      while (write_in_progress !== 1'b0 && k < 2000) begin
         @(posedge i_core_clk);
         k++;
      end
      repeat (3) @(posedge i_core_clk);
      #2;
   endtask
   task automatic wr_status(input logic [7:0] sr, input logic [7:0] sr4);
      host.send({`SFWP_OP_WRITE_ENABLE_CMD, 32'h0}, 8);
      host.send({`SFWP_OP_SRW, sr, 24'h0}, 16);
      settle();
      host.send({`SFWP_OP_WRITE_ENABLE_CMD, 32'h0}, 8);
      host.send({`SFWP_OP_SRW4, sr4, 24'h0}, 16);
      settle();
      check("block_protect", sr[4:2], bp);
      check("granularity", sr[6], gran);
      check("top_bottom", sr[5], tb);
      check("status_lock", sr[7], lock);
      check("complement", sr4[0], cmp);
      check("pin_disable", sr4[1], pdis);
      check("hold_disable", sr4[2], hdis);
   endtask
   task automatic try(input logic [7:0] op, input logic [23:0] a, input int n, input logic ok, input int len);
      int r;
      host.send({`SFWP_OP_WRITE_ENABLE_CMD, 32'h0}, 8);
      r = rej_cnt;
      host.send({op, a, 8'h0}, n);
      check("busy_started", ok, write_in_progress);
      check("active", ok, act);
      check("rejected", !ok, rej_cnt != r);
      settle();
      check("latch_after", !ok, write_enable_latch);
      check("standby_after", 1, stby);
      if (ok) check("busy_len", len, last_len);
   endtask
   task automatic summarize();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge i_core_clk);
      #2 i_srst = 1'b0;
      check("standby", 1, stby);
      check("blocked", 1, blk);
      check("latch", 0, write_enable_latch);
      host.send({`SFWP_OP_WRITE_ENABLE_CMD, 32'h0}, 8);
      check("latch_set", 1, write_enable_latch);
      host.send({`SFWP_OP_SRW, 8'h1c, 24'h0}, 16);
      check("early_write", 0, write_in_progress);
      check("early_bp", 0, bp);
      while (blk !== 1'b0 && cyc < 5000) @(posedge i_core_clk);
      #2;
      wr_status(8'h04, 8'h00);
      try(`SFWP_OP_SECT, 24'h070000, 32, 0, 16);
      try(`SFWP_OP_BLK, 24'h060000, 32, 1, 16);
      wr_status(8'h28, 8'h00);
      try(`SFWP_OP_HBLK, 24'h018000, 32, 0, 16);
      try(`SFWP_OP_PROG, 24'h020000, 40, 1, 12);
      wr_status(8'h4c, 8'h00);
      try(`SFWP_OP_QPROG, 24'h07c100, 40, 0, 12);
      try(`SFWP_OP_SECT, 24'h07b000, 32, 1, 16);
      wr_status(8'h74, 8'h00);
      try(`SFWP_OP_SECT, 24'h007000, 32, 0, 16);
      try(`SFWP_OP_SECT, 24'h008000, 32, 1, 16);
      wr_status(8'h44, 8'h01);
      try(`SFWP_OP_SECT, 24'h07e000, 32, 0, 16);
      try(`SFWP_OP_SECT, 24'h07f000, 32, 1, 16);
      wr_status(8'h10, 8'h00);
      try(`SFWP_OP_CHIP, 24'h0, 8, 0, 16);
      wr_status(8'h84, 8'h00);
      i_wp_n = 1'b0;
      host.send({`SFWP_OP_WRITE_ENABLE_CMD, 32'h0}, 8);
      host.send({`SFWP_OP_SRW, 8'h80, 24'h0}, 16);
      settle();
      check("locked_bp", 3'b001, bp);
      check("latch_kept", 1, write_enable_latch);
      // Latch survives the refused write, so no second enable is needed here
      host.send({`SFWP_OP_SRW4, 8'h06, 24'h0}, 16);
      settle();
      check("locked_pin_disable", 0, pdis);
      check("locked_hold", 0, hdis);
      i_wp_n = 1'b1;
      repeat (4) @(posedge i_core_clk);
      #2;
      wr_status(8'h84, 8'h06);
      i_wp_n = 1'b0;
      // Pin disable set: the low protect pin no longer locks the status bits
      wr_status(8'h00, 8'h00);
      i_wp_n = 1'b1;
      try(`SFWP_OP_CHIP, 24'h0, 8, 1, 16);
      try(`SFWP_OP_SECT, 24'h001000, 33, 0, 16);
      try(`SFWP_OP_SECT, 24'h001000, 40, 1, 16);
      host.send({`SFWP_OP_WRITE_ENABLE_CMD, 32'h0}, 8);
      fork
         host.send({`SFWP_OP_WRITE_DISABLE_CMD, 32'h0}, 8);
         begin
            #1000 check("selected", 1, act);
         end
      join
      check("write_disable_cmd_latch", 0, write_enable_latch);
      host.send({`SFWP_OP_SECT, 32'h0}, 32);
      check("no_latch", 0, write_in_progress);
      host.send({`SFWP_OP_DPD, 32'h0}, 8);
      check("power_down", 1, dpd);
      host.send({`SFWP_OP_WRITE_ENABLE_CMD, 32'h0}, 8);
      check("dpd_latch", 0, write_enable_latch);
      host.send({`SFWP_OP_REL, 32'h0}, 8);
      check("released", 0, dpd);
      summarize();
   end
endmodule
